// *** hdl/capture_compare_pwm_unit.sv ***
// Contract
// - Mode zero turns module off, resets state
// - Modes one to three enable nothing
// - Capture modes select edge and prescale
// - Mode 1000 sets output, flags on match
// - Mode 1001 clears output, flags on match
// - Mode 1010 flags only, pin untouched
// - Mode 1011 flags, clears timer, starts ADC if enabled
// - Modes 11xx are PWM, duty from two places
// - Control bits 7-6 read zero
// - Capture copies full first timer count
// - Captures set sticky flag, software clears
// - Newer capture overwrites older value
// - Edge detector sees pin even when driven
// - Prescaler cleared when off or not capturing
// - Prescale change keeps counter; software zeroes first
// - Capture/compare use first timer, PWM second
// - Compare value pair against first timer
// - Writing zero forces compare latch low
// - Period end clears timer, sets pin unless new duty is zero, latches duty
// - Pin clears on duty match; high read-only
//
// Implementation choices: the register addresses and the APB register port.
`timescale 1ns/100ps
`default_nettype none

module capture_compare_pwm_unit
    import ccp_unit_pkg::*;
(
    input  wire logic        core_clk,        // System clock, 125 MHz
    input  wire logic        rst,             // Async reset, active high
    input  wire logic        psel,            // APB select
    input  wire logic        penable,         // APB access phase
    input  wire logic        pwrite,          // APB direction
    input  wire logic [7:0]  paddr,           // APB byte address
    input  wire logic [31:0] pwdata,          // APB write data
    output logic      [31:0] prdata,          // APB read data
    output logic             pready,          // APB ready
    output logic             pslverr,         // APB error, unmapped address
    input  wire logic [15:0] firstTimerCount, // First timer count
    input  wire logic        adcEnable,       // Converter enabled
    output logic             firstTimerClear, // Pulse, reset first timer
    output logic             adcStart,        // Pulse, start a conversion
    input  wire logic        modulePinIn,     // Pin level, asynchronous
    output logic             modulePinOut,    // Pin drive value
    output logic             modulePinOeN,    // Pin enable, low drives
    output logic             moduleEventFlag  // Sticky event flag
);

    typedef struct packed {
        logic [5:0]  ctrl;
        logic [7:0]  valueLow;
        logic [7:0]  valueHigh;
        logic [7:0]  period;
        logic [7:0]  timerTwo;
        logic [1:0]  quarter;
        logic [1:0]  dutyLatchLo;
        logic [3:0]  prescale;
        logic        flag;
        logic        cmpLatch;
        logic        pwmPin;
        logic        matchPrev;
        logic        pinPrev;
        logic        timerClr;
        logic        adcGo;
        logic        pinDrive;
        logic        pinOeN;
        logic        ready;
        logic        slvErr;
        logic [31:0] rdata;
    } state_s;

    state_s st_r;
    state_s st_nxt;

    logic       pinLevel;
    logic [3:0] mode;
    logic       capMode;
    logic       cmpMode;
    logic       pwmMode;
    logic       pinRise;
    logic       pinFall;
    logic       captureEvent;
    logic       match;
    logic       matchRise;
    logic       access;
    logic       wrCtrl;
    logic       clrEvent;
    logic       pwmWrap;
    logic [9:0] pwmBase;
    logic [9:0] dutyLatched;
    logic       mapped;

    // Pin seen regardless of direction
    pin_sync u_pin_sync (
        .core_clk (core_clk),
        .rst      (rst),
        .pinAsync (modulePinIn),
        .pinLevel (pinLevel)
    );

    assign mode    = st_r.ctrl[MODE_MSB:MODE_LSB];
    // Reserved codes fall in none of the three groups
    assign capMode = (mode[3:2] == 2'b01);
    assign cmpMode = (mode[3:2] == 2'b10);
    assign pwmMode = (mode[3:2] == 2'b11);

    assign pinRise = pinLevel & ~st_r.pinPrev;
    assign pinFall = ~pinLevel & st_r.pinPrev;

    always_comb begin
        captureEvent = 1'b0;
        case (mode)
            MODE_CAP_FALL: captureEvent = pinFall;
            MODE_CAP_RISE: captureEvent = pinRise;
            MODE_CAP_4TH:  captureEvent = pinRise && (st_r.prescale == PRESCALE_FOURTH);
            MODE_CAP_16TH: captureEvent = pinRise && (st_r.prescale == PRESCALE_SIXTEENTH);
            default:       captureEvent = 1'b0;
        endcase
    end

    // Equality against first timer, acted on once per match
    assign match     = cmpMode && (firstTimerCount == {st_r.valueHigh, st_r.valueLow});
    assign matchRise = match && !st_r.matchPrev;

    assign pwmBase     = {st_r.timerTwo, st_r.quarter};
    assign dutyLatched = {st_r.valueHigh, st_r.dutyLatchLo};
    assign pwmWrap     = pwmMode && (st_r.quarter == QUARTER_LAST) && (st_r.timerTwo == st_r.period);

    assign access   = psel && penable && st_r.ready;
    assign wrCtrl   = access && pwrite && (paddr == CTRL_OFFSET);
    assign clrEvent = access && pwrite && (paddr == EVENT_OFFSET) && pwdata[EVENT_BIT];
    assign mapped   = (paddr == CTRL_OFFSET) || (paddr == VALUE_LOW_OFFSET)
                   || (paddr == VALUE_HI_OFFSET) || (paddr == EVENT_OFFSET)
                   || (paddr == PERIOD_OFFSET) || (paddr == TIMER_TWO_OFFSET);

    always_comb begin
        st_nxt = st_r;
        st_nxt.pinPrev   = pinLevel;
        st_nxt.matchPrev = match;
        st_nxt.timerClr  = 1'b0;
        st_nxt.adcGo     = 1'b0;

        // Register writes
        if (access && pwrite) begin
            case (paddr)
                CTRL_OFFSET:      st_nxt.ctrl = pwdata[5:0];
                VALUE_LOW_OFFSET: st_nxt.valueLow = pwdata[7:0];
                VALUE_HI_OFFSET: begin
                    if (!pwmMode) begin
                        st_nxt.valueHigh = pwdata[7:0];
                    end
                end
                PERIOD_OFFSET:    st_nxt.period = pwdata[7:0];
                default:          st_nxt.period = st_r.period;
            endcase
        end

        // Prescale counts rising edges only while capturing
        if (!capMode) begin
            st_nxt.prescale = 4'h0;
        end else if (pinRise) begin
            // Prescale switch keeps the count on purpose
            if (mode == MODE_CAP_4TH && st_r.prescale == PRESCALE_FOURTH) begin
                st_nxt.prescale = 4'h0;
            end else begin
                st_nxt.prescale = 4'(st_r.prescale + 4'h1);
            end
        end

        // Newest capture always wins
        if (capMode && captureEvent) begin
            st_nxt.valueHigh = firstTimerCount[15:8];
            st_nxt.valueLow  = firstTimerCount[7:0];
        end

        if (matchRise) begin
            case (mode)
                MODE_CMP_SET:   st_nxt.cmpLatch = 1'b1;
                MODE_CMP_CLEAR: st_nxt.cmpLatch = 1'b0;
                MODE_CMP_SPEC: begin
                    st_nxt.timerClr = 1'b1;
                    st_nxt.adcGo    = adcEnable;
                end
                default:        st_nxt.cmpLatch = st_r.cmpLatch;
            endcase
        end

        // Second timer and PWM output
        if (!pwmMode) begin
            st_nxt.timerTwo    = 8'h00;
            st_nxt.quarter     = 2'h0;
            st_nxt.pwmPin      = 1'b0;
            st_nxt.dutyLatchLo = 2'h0;
        end else if (pwmWrap) begin
            st_nxt.timerTwo    = 8'h00;
            st_nxt.quarter     = 2'h0;
            st_nxt.valueHigh   = st_r.valueLow;
            st_nxt.dutyLatchLo = st_r.ctrl[DUTY_LO_MSB:DUTY_LO_LSB];
            st_nxt.pwmPin      = ({st_r.valueLow, st_r.ctrl[DUTY_LO_MSB:DUTY_LO_LSB]} != 10'h000);
        end else begin
            {st_nxt.timerTwo, st_nxt.quarter} = 10'(pwmBase + 10'h001);
            // Pin is registered, so match the base being stepped to
            if (10'(pwmBase + 10'h001) == dutyLatched) begin
                st_nxt.pwmPin = 1'b0;
            end
        end

        // Off clears the compare latch and match history
        if (mode == MODE_OFF) begin
            st_nxt.cmpLatch  = 1'b0;
            st_nxt.matchPrev = 1'b0;
        end
        if (wrCtrl && pwdata[5:0] == CTRL_RESET) begin
            st_nxt.cmpLatch = 1'b0;
        end

        // Set beats a same-cycle clear
        if ((capMode && captureEvent) || matchRise) begin
            st_nxt.flag = 1'b1;
        end else if (clrEvent) begin
            st_nxt.flag = 1'b0;
        end

        // Pin released unless a driving mode is active
        st_nxt.pinOeN   = !(pwmMode || mode == MODE_CMP_SET || mode == MODE_CMP_CLEAR);
        st_nxt.pinDrive = pwmMode ? st_nxt.pwmPin : st_nxt.cmpLatch;

        // APB: one wait state, answer from a flop
        st_nxt.ready  = psel && penable && !st_r.ready;
        st_nxt.slvErr = 1'b0;
        st_nxt.rdata  = 32'h0000_0000;
        if (psel && penable && !st_r.ready) begin
            st_nxt.slvErr = !mapped;
            case (paddr)
                CTRL_OFFSET:      st_nxt.rdata = {26'h0, st_r.ctrl};
                VALUE_LOW_OFFSET: st_nxt.rdata = {24'h0, st_r.valueLow};
                VALUE_HI_OFFSET:  st_nxt.rdata = {24'h0, st_r.valueHigh};
                EVENT_OFFSET:     st_nxt.rdata = {31'h0, st_r.flag};
                PERIOD_OFFSET:    st_nxt.rdata = {24'h0, st_r.period};
                TIMER_TWO_OFFSET: st_nxt.rdata = {24'h0, st_r.timerTwo};
                default:          st_nxt.rdata = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st_r           <= '0;
            st_r.ctrl      <= CTRL_RESET;
            st_r.valueLow  <= VALUE_RESET;
            st_r.valueHigh <= VALUE_RESET;
            st_r.period    <= PERIOD_RESET;
            st_r.pinOeN    <= 1'b1;
        end else begin
            st_r <= st_nxt;
        end
    end

    assign prdata          = st_r.rdata;
    assign pready          = st_r.ready;
    assign pslverr         = st_r.slvErr;
    assign firstTimerClear = st_r.timerClr;
    assign adcStart        = st_r.adcGo;
    assign modulePinOut    = st_r.pinDrive;
    assign modulePinOeN    = st_r.pinOeN;
    assign moduleEventFlag = st_r.flag;

    off_state_a: assert property (@(posedge core_clk) disable iff (rst)
        (mode == MODE_OFF) |=> (!st_r.cmpLatch && st_r.prescale == 4'h0 && modulePinOeN))
        else $error("Module not reset while off");

    reserved_quiet_a: assert property (@(posedge core_clk) disable iff (rst)
        (mode != MODE_OFF && mode[3:2] == 2'b00) |=> modulePinOeN)
        else $error("Reserved mode drives pin");

    capture_copy_a: assert property (@(posedge core_clk) disable iff (rst)
        (capMode && captureEvent)
        |=> ({st_r.valueHigh, st_r.valueLow} == $past(firstTimerCount) && moduleEventFlag))
        else $error("Capture did not copy timer");

    fourth_edge_a: assert property (@(posedge core_clk) disable iff (rst)
        (mode == MODE_CAP_4TH && captureEvent) |-> (pinRise && st_r.prescale == 4'h3))
        else $error("Quarter prescale wrong");

    set_match_a: assert property (@(posedge core_clk) disable iff (rst)
        (mode == MODE_CMP_SET && matchRise) |=> ##1 (modulePinOut && !modulePinOeN))
        else $error("Match did not set output");

    clear_match_a: assert property (@(posedge core_clk) disable iff (rst)
        (mode == MODE_CMP_CLEAR && matchRise && !wrCtrl) |=> (!st_r.cmpLatch && moduleEventFlag))
        else $error("Match did not clear output");

    swint_pin_a: assert property (@(posedge core_clk) disable iff (rst)
        (mode == MODE_CMP_SWINT) |=> modulePinOeN)
        else $error("Software interrupt mode drives pin");

    special_event_a: assert property (@(posedge core_clk) disable iff (rst)
        (mode == MODE_CMP_SPEC && matchRise)
        |=> (firstTimerClear && moduleEventFlag && adcStart == $past(adcEnable)))
        else $error("Special event incomplete");

    ctrl_high_a: assert property (@(posedge core_clk) disable iff (rst)
        (pready && paddr == CTRL_OFFSET && !pwrite) |-> (prdata[31:6] == 26'h0))
        else $error("Control upper bits not zero");

    flag_sticky_a: assert property (@(posedge core_clk) disable iff (rst)
        (moduleEventFlag && !clrEvent) |=> moduleEventFlag)
        else $error("Flag cleared by hardware");

    prescale_idle_a: assert property (@(posedge core_clk) disable iff (rst)
        !capMode |=> (st_r.prescale == 4'h0))
        else $error("Prescaler not cleared");

    pwm_wrap_a: assert property (@(posedge core_clk) disable iff (rst)
        pwmWrap |=> (st_r.timerTwo == 8'h00 && st_r.valueHigh == $past(st_r.valueLow)))
        else $error("Period end handling wrong");

endmodule

`default_nettype wire

// *** hdl/ccp_unit_pkg.sv ***
package ccp_unit_pkg;

    // Register byte offsets on the APB
    localparam logic [7:0] CTRL_OFFSET      = 8'h00;
    localparam logic [7:0] VALUE_LOW_OFFSET = 8'h04;
    localparam logic [7:0] VALUE_HI_OFFSET  = 8'h08;
    localparam logic [7:0] EVENT_OFFSET     = 8'h0c;
    localparam logic [7:0] PERIOD_OFFSET    = 8'h10;
    localparam logic [7:0] TIMER_TWO_OFFSET = 8'h14;

    // Control and event register field positions
    localparam int MODE_LSB    = 0;
    localparam int MODE_MSB    = 3;
    localparam int DUTY_LO_LSB = 4;
    localparam int DUTY_LO_MSB = 5;
    localparam int EVENT_BIT   = 0;

    // Reset values
    localparam logic [5:0] CTRL_RESET   = 6'h00;
    localparam logic [7:0] VALUE_RESET  = 8'h00;
    localparam logic [7:0] PERIOD_RESET = 8'h00;

    // Capture prescale terminal counts
    localparam logic [3:0] PRESCALE_FOURTH    = 4'h3;
    localparam logic [3:0] PRESCALE_SIXTEENTH = 4'hf;

    // Last quarter count before each second-timer increment
    localparam logic [1:0] QUARTER_LAST = 2'h3;

    typedef enum logic [3:0] {
        MODE_OFF       = 4'b0000,
        MODE_RES1      = 4'b0001,
        MODE_RES2      = 4'b0010,
        MODE_RES3      = 4'b0011,
        MODE_CAP_FALL  = 4'b0100,
        MODE_CAP_RISE  = 4'b0101,
        MODE_CAP_4TH   = 4'b0110,
        MODE_CAP_16TH  = 4'b0111,
        MODE_CMP_SET   = 4'b1000,
        MODE_CMP_CLEAR = 4'b1001,
        MODE_CMP_SWINT = 4'b1010,
        MODE_CMP_SPEC  = 4'b1011
    } mode_e;

endpackage

// *** hdl/pin_sync.sv ***
`timescale 1ns/100ps
`default_nettype none

module pin_sync (
    input  wire logic core_clk, // System clock
    input  wire logic rst,      // Async reset, active high
    input  wire logic pinAsync, // Raw pin level
    output logic      pinLevel  // Filtered, synchronised level
);

    logic [2:0] stage_r;
    logic       level_r;

    // First stage feeds only the second
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            stage_r <= 3'h0;
            level_r <= 1'b0;
        end else begin
            stage_r <= {stage_r[1:0], pinAsync};
            if (stage_r[1] == stage_r[2]) begin
                level_r <= stage_r[2];
            end
        end
    end

    assign pinLevel = level_r;

endmodule

`default_nettype wire

// *** verification/pin_partner.sv ***
`timescale 1ns/100ps
`default_nettype none

module pin_partner (
    input  wire logic srcLevel, // Level the outside source drives
    input  wire logic pinOut,   // Device drive value
    input  wire logic pinOeN,   // Device enable, low drives
    output logic      pinWire   // Resolved pin level
);
    // Source never floats, so the wire is always defined
    assign pinWire = !pinOeN ? pinOut : srcLevel;
endmodule

`default_nettype wire

// *** verification/tb_top.sv ***
`timescale 1ns/100ps
`default_nettype none

module tb_top;
    import ccp_unit_pkg::*;
    logic        core_clk, rst, psel, penable, pwrite, adcEnable, src;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rdata;
    logic        pready, pslverr, rerr, tClr, adcGo, pinOut, pinOeN, flag, pinWire;
    logic [15:0] tCount;
    int          error_cnt = 0, checks = 0, cyc = 0, clrCnt = 0, adcCnt = 0;

    capture_compare_pwm_unit capture_compare_pwm_unit_inst (
        .core_clk(core_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .firstTimerCount(tCount),
        .adcEnable(adcEnable), .firstTimerClear(tClr), .adcStart(adcGo),
        .modulePinIn(pinWire), .modulePinOut(pinOut), .modulePinOeN(pinOeN),
        .moduleEventFlag(flag)
    );
    pin_partner pin_partner_inst (
        .srcLevel(src), .pinOut(pinOut), .pinOeN(pinOeN), .pinWire(pinWire)
    );

    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        cyc++;
        if (tClr === 1'b1) clrCnt++;
        if (adcGo === 1'b1) adcCnt++;
        if (cyc == 20000) begin
            error_cnt++;
            conclude();
        end
    end

    task automatic conclude;
        $display("Comparisons %0d, mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask

    task automatic waitc(input int n);
        repeat (n) @(posedge core_clk);
    endtask

    // Request held until pready is sampled high, then released
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge core_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        // Only pready or the bench timeout ends this wait
        do begin
            @(posedge core_clk);
        end while (pready !== 1'b1);
        chk(pready, 1'b1, "apb ready");
        rdata = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask

    // Off first so the prescaler restarts, then drop any false flag
    task automatic setMode(input logic [7:0] m);
        wr(CTRL_OFFSET, 32'h0);
        wr(CTRL_OFFSET, {24'h0, m});
        wr(EVENT_OFFSET, 32'h1);
    endtask

    task automatic pulses(input int n);
        repeat (n) begin
            src <= 1'b1;
            waitc(8);
            src <= 1'b0;
            waitc(8);
        end
    endtask

    task automatic capVal(input logic [15:0] exp, input string what);
        logic [15:0] v;
        rd(VALUE_HI_OFFSET);
        v[15:8] = rdata[7:0];
        rd(VALUE_LOW_OFFSET);
        v[7:0] = rdata[7:0];
        chk(v, exp, what);
    endtask

    task automatic measure(input int exp, input string what);
        int hi;
        hi = 0;
        repeat (64) begin
            @(posedge core_clk);
            if (pinWire === 1'b1) hi++;
        end
        chk(hi, exp, what);
    endtask

    task automatic testRegs;
        rd(CTRL_OFFSET);
        chk(rdata, 32'h0, "ctrl reset");
        chk(pinOeN, 1'b1, "released after reset");
        wr(CTRL_OFFSET, 32'hff);
        rd(CTRL_OFFSET);
        chk(rdata, 32'h3f, "ctrl upper bits");
        wr(CTRL_OFFSET, 32'h0);
        rd(8'h20);
        chk(rerr, 1'b1, "unmapped error");
        chk(rdata, 32'h0, "unmapped data");
        $display("test regs done");
    endtask

    task automatic testCapture;
        setMode(MODE_CAP_FALL);
        tCount <= 16'h1111;
        src <= 1'b1;
        waitc(8);
        chk(flag, 1'b0, "rise ignored");
        tCount <= 16'hbeef;
        src <= 1'b0;
        waitc(8);
        chk(flag, 1'b1, "fall captured");
        capVal(16'hbeef, "fall value");
        setMode(MODE_CAP_RISE);
        tCount <= 16'ha5c3;
        pulses(1);
        tCount <= 16'h5a3c;
        pulses(1);
        capVal(16'h5a3c, "overwrite");
        waitc(50);
        chk(flag, 1'b1, "sticky flag");
        wr(EVENT_OFFSET, 32'h1);
        waitc(2);
        chk(flag, 1'b0, "flag cleared");
        setMode(MODE_CAP_4TH);
        pulses(3);
        chk(flag, 1'b0, "three of four");
        pulses(1);
        chk(flag, 1'b1, "fourth rise");
        setMode(MODE_CAP_4TH);
        pulses(2);
        setMode(MODE_CAP_4TH);
        pulses(3);
        chk(flag, 1'b0, "prescaler cleared");
        setMode(MODE_CAP_16TH);
        pulses(15);
        chk(flag, 1'b0, "fifteen of sixteen");
        pulses(1);
        chk(flag, 1'b1, "sixteenth rise");
        // Timer still equals the pair, so a live compare would flag too
        for (int m = 1; m < 4; m++) begin
            setMode(m[7:0]);
            pulses(2);
            chk(flag, 1'b0, "reserved no flag");
            chk(pinOeN, 1'b1, "reserved released");
        end
        $display("test capture done");
    endtask

    task automatic testCompare;
        wr(VALUE_LOW_OFFSET, 32'h34);
        wr(VALUE_HI_OFFSET, 32'h12);
        tCount <= 16'h0;
        setMode(MODE_CMP_SET);
        waitc(3);
        chk(flag, 1'b0, "no match yet");
        tCount <= 16'h1234;
        waitc(4);
        chk({pinOeN, pinOut, flag}, 3'b011, "set on match");
        tCount <= 16'h0;
        wr(CTRL_OFFSET, 32'h0);
        waitc(3);
        chk(pinOeN, 1'b1, "off releases");
        wr(CTRL_OFFSET, 32'h8);
        waitc(3);
        chk(pinOut, 1'b0, "latch forced low");
        tCount <= 16'h1234;
        waitc(4);
        chk(pinOut, 1'b1, "latch set again");
        tCount <= 16'h0;
        adcEnable <= 1'b1;
        for (int m = 9; m < 12; m++) begin
            // Straight from 1000 so the set latch must be cleared by the match
            if (m == 9) begin
                wr(CTRL_OFFSET, 32'h9);
                wr(EVENT_OFFSET, 32'h1);
            end else begin
                setMode(m[7:0]);
            end
            tCount <= 16'h1234;
            waitc(4);
            chk(flag, 1'b1, "flag on match");
            chk(pinOeN, m != 9, "pin control");
            if (m == 9) chk(pinOut, 1'b0, "clear on match");
            tCount <= 16'h0;
        end
        chk(clrCnt, 1, "timer reset pulse");
        chk(adcCnt, 1, "conversion start");
        adcEnable <= 1'b0;
        waitc(2);
        tCount <= 16'h1234;
        waitc(4);
        chk(clrCnt, 2, "second reset pulse");
        chk(adcCnt, 1, "no start when off");
        $display("test compare done");
    endtask

    task automatic testPwm;
        wr(PERIOD_OFFSET, 32'h3);
        wr(VALUE_LOW_OFFSET, 32'h1);
        setMode(8'h2c);
        waitc(40);
        measure(24, "duty six of sixteen");
        rd(VALUE_HI_OFFSET);
        chk(rdata, 32'h1, "duty latched");
        wr(VALUE_HI_OFFSET, 32'h55);
        rd(VALUE_HI_OFFSET);
        chk(rdata, 32'h1, "high read-only");
        wr(VALUE_LOW_OFFSET, 32'h0);
        wr(CTRL_OFFSET, 32'h0f);
        waitc(40);
        measure(0, "zero duty");
        chk(pinOeN, 1'b0, "pwm drives");
        wr(CTRL_OFFSET, 32'h0);
        waitc(3);
        chk(pinOeN, 1'b1, "off releases pwm");
        rd(TIMER_TWO_OFFSET);
        chk(rdata, 32'h0, "second timer idle");
        $display("test pwm done");
    endtask

    initial begin
        rst = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h0;
        pwdata = 32'h0;
        tCount = 16'h0;
        adcEnable = 1'b0;
        src = 1'b0;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        testRegs();
        testCapture();
        testCompare();
        testPwm();
        conclude();
    end
endmodule

`default_nettype wire
